//--- core/ep_status_pkg.sv
package ep_status_pkg;

  // ----------------------------------------------------------------
  // Endpoint indexing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_EP      = 16;
  localparam int unsigned EP_IDX_W    = 4;
  localparam logic [3:0]  EP_CTRL_OUT = 4'h0;
  localparam logic [3:0]  EP_CTRL_IN  = 4'h1;

  // ----------------------------------------------------------------
  // Command codes: high nibble is the command, low nibble the index
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_STALL      = 4'h4;
  localparam logic [3:0]  CMD_READ_STAT  = 4'h5;
  localparam logic [3:0]  CMD_VALIDATE   = 4'h6;
  localparam logic [3:0]  CMD_UNSTALL    = 4'h8;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned STAT_W            = 8;
  localparam int unsigned BIT_STALL         = 7;
  localparam int unsigned BIT_SEC_FULL      = 6;
  localparam int unsigned BIT_PRI_FULL      = 5;
  localparam int unsigned BIT_TOGGLE        = 4;
  localparam int unsigned BIT_SETUP_FLAG_A     = 3;
  localparam int unsigned BIT_SETUP_PRESENT = 2;
  localparam int unsigned BIT_CPU_SEL       = 1;
  localparam int unsigned BIT_RESERVED      = 0;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam logic [15:0] RD_DATA_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // Token kinds from the serial engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TOK_OUT   = 2'b00,
    TOK_IN    = 2'b01,
    TOK_SETUP = 2'b10
  } token_kind_t;

endpackage : ep_status_pkg

//--- core/ep_status_cell.sv
`timescale 1ns/10ps
module ep_status_cell
  import ep_status_pkg::*;
#(
  parameter bit IS_DOUBLE = 1'b0
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         nrst_i,
  input  wire logic                         stall_i,
  input  wire logic                         unstall_i,
  input  wire logic                         setup_tok_i,
  input  wire logic                         validate_i,
  input  wire logic                         setup_wr_i,
  input  wire logic                         setup_done_i,
  input  wire logic                         setup_ack_i,
  input  wire logic                         status_rd_i,
  input  wire logic                         pkt_done_i,
  output logic [ep_status_pkg::STAT_W-1:0]  status_o,
  output logic                              usb_full_o
);
  import ep_status_pkg::*;

  logic stall_reg, pri_full_reg, sec_full_reg, toggle_reg;
  logic setup_flag_a_reg, setup_present_reg, cpu_sel_reg, usb_sel_reg;
  logic setup_pending_reg, setup_writing_reg;
  logic reinit;

  // Reinit only when leaving a real stall
  assign reinit = stall_reg & (unstall_i | setup_tok_i);

  // ----------------------------------------------------------------
  // Stall and buffer state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stall_reg    <= 1'b0;
      pri_full_reg <= 1'b0;
      sec_full_reg <= 1'b0;
      toggle_reg   <= 1'b0;
      cpu_sel_reg  <= 1'b0;
      usb_sel_reg  <= 1'b0;
    end else begin
      if (stall_i) begin
        stall_reg <= 1'b1;
      end else if (unstall_i || setup_tok_i) begin
        stall_reg <= 1'b0;
      end
      if (reinit) begin
        pri_full_reg <= 1'b0;
        sec_full_reg <= 1'b0;
        toggle_reg   <= 1'b0;
        cpu_sel_reg  <= 1'b0;
        usb_sel_reg  <= 1'b0;
      end else begin
        if (validate_i) begin
          if (IS_DOUBLE && cpu_sel_reg) begin
            sec_full_reg <= 1'b1;
          end else begin
            pri_full_reg <= 1'b1;
          end
          if (IS_DOUBLE) begin
            cpu_sel_reg <= ~cpu_sel_reg;
          end
        end
        if (pkt_done_i) begin
          toggle_reg <= ~toggle_reg;
          if (IS_DOUBLE) begin
            usb_sel_reg <= ~usb_sel_reg;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Setup tracking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      setup_present_reg <= 1'b0;
      setup_pending_reg <= 1'b0;
      setup_writing_reg <= 1'b0;
      setup_flag_a_reg     <= 1'b0;
    end else begin
      if (setup_wr_i) begin
        setup_present_reg <= 1'b1;
      end else if (setup_ack_i) begin
        setup_present_reg <= 1'b0;
      end
      // Stalling or acking ends the pending setup
      if (setup_wr_i) begin
        setup_pending_reg <= 1'b1;
      end else if (setup_ack_i || stall_i) begin
        setup_pending_reg <= 1'b0;
      end
      if (setup_wr_i) begin
        setup_writing_reg <= 1'b1;
      end else if (setup_done_i) begin
        setup_writing_reg <= 1'b0;
      end
      // Set wins over a read in the same cycle
      if (setup_wr_i && setup_pending_reg) begin
        setup_flag_a_reg <= 1'b1;
      end else if (status_rd_i && !setup_writing_reg) begin
        setup_flag_a_reg <= 1'b0;
      end
    end
  end

  // Side being served on the bus
  assign usb_full_o = (IS_DOUBLE && usb_sel_reg) ? sec_full_reg
                                                 : pri_full_reg;

  always_comb begin
    status_o                    = STATUS_RESET;
    status_o[BIT_STALL]         = stall_reg;
    status_o[BIT_SEC_FULL]      = sec_full_reg;
    status_o[BIT_PRI_FULL]      = pri_full_reg;
    status_o[BIT_TOGGLE]        = toggle_reg;
    status_o[BIT_SETUP_FLAG_A]     = setup_flag_a_reg;
    status_o[BIT_SETUP_PRESENT] = setup_present_reg;
    status_o[BIT_CPU_SEL]       = cpu_sel_reg;
    status_o[BIT_RESERVED]      = 1'b0;
  end

endmodule : ep_status_cell

//--- core/ep_status_ctrl.sv
`timescale 1ns/10ps
module ep_status_ctrl
  import ep_status_pkg::*;
#(
  parameter logic [15:0] DOUBLE_MASK = 16'h0000,
  parameter logic [15:0] IN_MASK     = 16'h0002
) (
  input  wire logic                                 ref_clk_i,
  input  wire logic                                 nrst_i,
  input  wire logic                                 cmd_valid_i,
  input  wire logic [7:0]                           cmd_code_i,
  output logic                                      rd_valid_o,
  output logic [15:0]                               rd_data_o,
  output logic [ep_status_pkg::NUM_EP-1:0]          int_clr_o,
  input  wire logic                                 tok_valid_i,
  input  wire ep_status_pkg::token_kind_t           tok_kind_i,
  input  wire logic [3:0]                           tok_ep_i,
  input  wire logic                                 setup_wr_i,
  input  wire logic                                 setup_done_i,
  input  wire logic                                 setup_ack_i,
  input  wire logic                                 pkt_done_i,
  input  wire logic [ep_status_pkg::EP_IDX_W-1:0]   pkt_idx_i,
  output logic                                      stall_hs_o,
  output logic                                      in_send_o,
  output logic                                      in_nak_o,
  output logic                                      in_pid_o,
  output logic                                      out_accept_o
);
  import ep_status_pkg::*;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [3:0]        cmd_op;
  logic [3:0]        cmd_idx;
  logic              do_stall, do_unstall, do_validate, do_read;
  logic [NUM_EP-1:0] stall_vec, unstall_vec, validate_vec, read_vec;

  assign cmd_op  = cmd_code_i[7:4];
  assign cmd_idx = cmd_code_i[3:0];

  // Single-byte commands: only the read status command is followed by a data word
  assign do_stall   = cmd_valid_i && (cmd_op == CMD_STALL);
  assign do_unstall = cmd_valid_i && (cmd_op == CMD_UNSTALL);
  assign do_read    = cmd_valid_i && (cmd_op == CMD_READ_STAT);
  // Index 0 is control OUT, not a valid target
  assign do_validate = cmd_valid_i && (cmd_op == CMD_VALIDATE)
                       && (cmd_idx != EP_CTRL_OUT);

  // ----------------------------------------------------------------
  // Token mapping: endpoint number to status index
  // ----------------------------------------------------------------
  logic [3:0]        tok_idx;
  logic              tok_is_setup;
  logic [NUM_EP-1:0] setup_vec, setup_wr_vec, setup_done_vec;
  logic [NUM_EP-1:0] setup_ack_vec, pkt_vec;

  // Control IN shares endpoint 0 on the bus
  always_comb begin
    if (tok_ep_i == 4'h0) begin
      tok_idx = (tok_kind_i == TOK_IN) ? EP_CTRL_IN : EP_CTRL_OUT;
    end else begin
      tok_idx = tok_ep_i + 4'h1;
    end
  end

  assign tok_is_setup = tok_valid_i && (tok_kind_i == TOK_SETUP)
                        && (tok_ep_i == 4'h0);

  // ----------------------------------------------------------------
  // Per-endpoint status cells
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] status_arr [NUM_EP];
  logic [NUM_EP-1:0] usb_full_vec;
  logic [NUM_EP-1:0] stall_vec_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      localparam logic [3:0] IDX = 4'(gi);
      localparam bit IS_CTRL = (gi < 2);

      assign stall_vec[gi]   = do_stall && (cmd_idx == IDX);
      assign unstall_vec[gi] = do_unstall && (cmd_idx == IDX);
      // Validate acts on IN endpoints only
      assign validate_vec[gi] = do_validate && (cmd_idx == IDX)
                                && IN_MASK[gi];
      assign read_vec[gi]  = do_read && (cmd_idx == IDX);
      // SETUP reaches both halves of the control endpoint
      assign setup_vec[gi] = tok_is_setup && IS_CTRL;
      assign setup_wr_vec[gi]   = setup_wr_i && (gi == 0);
      assign setup_done_vec[gi] = setup_done_i && (gi == 0);
      assign setup_ack_vec[gi]  = setup_ack_i && IS_CTRL;
      assign pkt_vec[gi] = pkt_done_i && (pkt_idx_i == IDX);
      assign stall_vec_q[gi] = status_arr[gi][BIT_STALL];

      ep_status_cell #(
        .IS_DOUBLE (DOUBLE_MASK[gi])
      ) u_cell (
        .ref_clk_i    (ref_clk_i),
        .nrst_i       (nrst_i),
        .stall_i      (stall_vec[gi]),
        .unstall_i    (unstall_vec[gi]),
        .setup_tok_i  (setup_vec[gi]),
        .validate_i   (validate_vec[gi]),
        .setup_wr_i   (setup_wr_vec[gi]),
        .setup_done_i (setup_done_vec[gi]),
        .setup_ack_i  (setup_ack_vec[gi]),
        .status_rd_i  (read_vec[gi]),
        .pkt_done_i   (pkt_vec[gi]),
        .status_o     (status_arr[gi]),
        .usb_full_o   (usb_full_vec[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status read port
  // ----------------------------------------------------------------
  // Upper byte of the word reads zero
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= RD_DATA_RESET;
    end else begin
      rd_valid_o <= do_read;
      if (do_read) begin
        rd_data_o <= {8'h00, status_arr[cmd_idx]};
      end
    end
  end

  // One pulse per read, to the interrupt register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_clr_o <= '0;
    end else begin
      int_clr_o <= read_vec;
    end
  end

  // ----------------------------------------------------------------
  // Token answers
  // ----------------------------------------------------------------
  logic tok_stalled;
  logic tok_in, tok_out;

  assign tok_stalled = stall_vec_q[tok_idx];
  assign tok_in  = tok_valid_i && (tok_kind_i == TOK_IN);
  assign tok_out = tok_valid_i && (tok_kind_i == TOK_OUT);

  // SETUP is never stalled, it always gets through
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stall_hs_o   <= 1'b0;
      in_send_o    <= 1'b0;
      in_nak_o     <= 1'b0;
      in_pid_o     <= 1'b0;
      out_accept_o <= 1'b0;
    end else begin
      stall_hs_o <= (tok_in || tok_out) && tok_stalled;
      in_send_o  <= tok_in && !tok_stalled
                    && usb_full_vec[tok_idx];
      in_nak_o   <= tok_in && !tok_stalled
                    && !usb_full_vec[tok_idx];
      out_accept_o <= tok_out && !tok_stalled
                      && !usb_full_vec[tok_idx];
      if (tok_in) begin
        in_pid_o <= status_arr[tok_idx][BIT_TOGGLE];
      end
    end
  end

endmodule : ep_status_ctrl

//--- sim/ep_status_ctrl_sva.sv
`timescale 1ns/10ps
module ep_status_chk
  import ep_status_pkg::*;
(
  input wire logic                            ref_clk_i,
  input wire logic                            nrst_i,
  input wire logic                            cmd_valid_i,
  input wire logic [7:0]                      cmd_code_i,
  input wire logic                            rd_valid_o,
  input wire logic [15:0]                     rd_data_o,
  input wire logic [ep_status_pkg::NUM_EP-1:0] int_clr_o,
  input wire logic                            tok_valid_i,
  input wire logic                            stall_hs_o,
  input wire logic                            in_send_o,
  input wire logic                            in_nak_o,
  input wire logic                            out_accept_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire rd_cmd = cmd_valid_i && cmd_code_i[7:4] == CMD_READ_STAT;
  wire any_rsp = stall_hs_o || in_send_o || in_nak_o || out_accept_o;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_ans;
    rd_cmd |=> rd_valid_o && int_clr_o == (16'h1 << $past(cmd_code_i[3:0]));
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer wrong");
  property p_rd_only;
    !rd_cmd |=> !rd_valid_o && int_clr_o == 16'h0000;
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("stray read pulse");
  property p_rd_fmt;
    rd_valid_o |-> rd_data_o[15:8] == 8'h00 && rd_data_o[0] == 1'b0;
  endproperty
  a_rd_fmt: assert property (p_rd_fmt)
    else $error("read format wrong");
  property p_rd_hold;
    !rd_valid_o |-> $stable(rd_data_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_stall;
    (cmd_valid_i && cmd_code_i[7:4] == CMD_STALL) ##1
    (rd_cmd && cmd_code_i[3:0] == $past(cmd_code_i[3:0])) |=> rd_data_o[7];
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall not shown");
  property p_unstall;
    (cmd_valid_i && cmd_code_i[7:4] == CMD_UNSTALL) ##1
    (rd_cmd && cmd_code_i[3:0] == $past(cmd_code_i[3:0])) |=> !rd_data_o[7];
  endproperty
  a_unstall: assert property (p_unstall)
    else $error("unstall not shown");
  property p_rsp_one;
    $onehot0({stall_hs_o, in_send_o, in_nak_o, out_accept_o});
  endproperty
  a_rsp_one: assert property (p_rsp_one)
    else $error("two answers");
  property p_rsp_cause;
    any_rsp |-> $past(tok_valid_i);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("answer no token");
  c_rd: cover property (rd_valid_o);
  c_stall_hs: cover property (stall_hs_o);
  c_send: cover property (in_send_o);
endmodule : ep_status_chk

bind ep_status_ctrl ep_status_chk chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
  .int_clr_o(int_clr_o), .tok_valid_i(tok_valid_i),
  .stall_hs_o(stall_hs_o), .in_send_o(in_send_o), .in_nak_o(in_nak_o),
  .out_accept_o(out_accept_o));

//--- sim/usb_host_model.sv
`timescale 1ns/10ps
module usb_host_model
  import ep_status_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 stall_hs_i,
  input  wire logic                 in_send_i,
  input  wire logic                 in_nak_i,
  input  wire logic                 in_pid_i,
  input  wire logic                 out_accept_i,
  output ep_status_pkg::token_kind_t tok_kind_o,
  output logic                      tok_valid_o = 1'b0,
  output logic [3:0]                tok_ep_o = 4'h0,
  output logic                      setup_wr_o = 1'b0,
  output logic                      setup_done_o = 1'b0
);
  initial tok_kind_o = TOK_OUT;
  // One token; answer gathered over two cycles, pid last
  task automatic tok(input token_kind_t k, input logic [3:0] ep,
                     output logic [4:0] r);
    r = 5'h00;
    tok_valid_o = 1'b1;
    tok_kind_o = k;
    tok_ep_o = ep;
    @(negedge ref_clk_i);
    tok_valid_o = 1'b0;
    // Idle lines flip so stale values cannot pass
    tok_ep_o = ~ep;
    tok_kind_o = token_kind_t'(~k);
    repeat (2) begin
      r[4:1] = r[4:1] | {stall_hs_i, in_send_i, in_nak_i, out_accept_i};
      r[0] = in_pid_i;
      @(negedge ref_clk_i);
    end
  endtask : tok
  task automatic setup_pkt();
    setup_wr_o = 1'b1;
    @(negedge ref_clk_i);
    setup_wr_o = 1'b0;
    @(negedge ref_clk_i);
    setup_done_o = 1'b1;
    @(negedge ref_clk_i);
    setup_done_o = 1'b0;
  endtask : setup_pkt
endmodule : usb_host_model

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
  import ep_status_pkg::*;
  logic        ref_clk_i = 1'b0, nrst_i = 1'b0, cmd_valid_i = 1'b0;
  logic        setup_ack_i = 1'b0, pkt_done_i = 1'b0;
  logic [7:0]  cmd_code_i = 8'h00;
  logic [3:0]  pkt_idx_i = 4'h0, tok_ep_i;
  logic [15:0] rd_data_o, int_clr_o;
  logic        rd_valid_o, tok_valid_i, setup_wr_i, setup_done_i;
  logic        stall_hs_o, in_send_o, in_nak_o, in_pid_o, out_accept_o;
  token_kind_t tok_kind_i;
  logic [4:0]  r;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // Index 2 is a double-buffered IN endpoint
  ep_status_ctrl #(.DOUBLE_MASK(16'h0004), .IN_MASK(16'h0006)) dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .int_clr_o(int_clr_o),
    .tok_valid_i(tok_valid_i), .tok_kind_i(tok_kind_i),
    .tok_ep_i(tok_ep_i), .setup_wr_i(setup_wr_i),
    .setup_done_i(setup_done_i), .setup_ack_i(setup_ack_i),
    .pkt_done_i(pkt_done_i), .pkt_idx_i(pkt_idx_i),
    .stall_hs_o(stall_hs_o), .in_send_o(in_send_o), .in_nak_o(in_nak_o),
    .in_pid_o(in_pid_o), .out_accept_o(out_accept_o));
  usb_host_model host (
    .ref_clk_i(ref_clk_i), .stall_hs_i(stall_hs_o), .in_send_i(in_send_o),
    .in_nak_i(in_nak_o), .in_pid_i(in_pid_o), .out_accept_i(out_accept_o),
    .tok_kind_o(tok_kind_i), .tok_valid_o(tok_valid_i),
    .tok_ep_o(tok_ep_i), .setup_wr_o(setup_wr_i),
    .setup_done_o(setup_done_i));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk8(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk8
  task automatic chk5(input string n, input logic [4:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk5
  task automatic chk16(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk16
  // Leaves valid up so a read can follow back to back
  task automatic cmd(input logic [7:0] c);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    @(negedge ref_clk_i);
  endtask : cmd
  // Idle edge after the drop keeps the next raise in a new step
  task automatic op(input logic [7:0] c);
    cmd(c);
    cmd_valid_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : op
  // Answer stands only in the cycle after the taking edge
  task automatic rd(input logic [3:0] i, input logic [7:0] e, m);
    cmd({CMD_READ_STAT, i});
    cmd_valid_i = 1'b0;
    chk16("read valid", 16'h0001, {15'h0000, rd_valid_o});
    chk16("int clear", 16'h0001 << i, int_clr_o);
    chk16("read upper", 16'h0000, {8'h00, rd_data_o[15:8]});
    chk8("status", e, rd_data_o[7:0] & m);
    @(negedge ref_clk_i);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_stall_all();
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], 8'h00, 8'hff);
      cmd({CMD_STALL, i[3:0]});
      rd(i[3:0], 8'h80, 8'hff);
      cmd({CMD_UNSTALL, i[3:0]});
      rd(i[3:0], 8'h00, 8'hff);
    end
  endtask : t_stall_all
  task automatic t_tokens();
    op(8'h43);
    host.tok(TOK_OUT, 4'h2, r);
    chk5("answer", 5'b10000, r);
    op(8'h83);
    host.tok(TOK_OUT, 4'h2, r);
    chk5("answer", 5'b00010, r);
    host.tok(TOK_IN, 4'h0, r);
    chk5("answer", 5'b00100, r);
  endtask : t_tokens
  task automatic t_validate();
    op(8'h62);
    rd(4'h2, 8'h22, 8'hff);
    op(8'h62);
    rd(4'h2, 8'h60, 8'hff);
    host.tok(TOK_IN, 4'h1, r);
    chk5("answer", 5'b01000, r);
    pkt_idx_i = 4'h2;
    pkt_done_i = 1'b1;
    @(negedge ref_clk_i);
    pkt_done_i = 1'b0;
    rd(4'h2, 8'h70, 8'hff);
    host.tok(TOK_IN, 4'h1, r);
    chk5("answer", 5'b01001, r);
    cmd(8'h42);
    rd(4'h2, 8'hf0, 8'hff);
    cmd(8'h82);
    rd(4'h2, 8'h00, 8'hff);
    op(8'h60);
    op(8'h63);
    rd(4'h3, 8'h00, 8'hff);
    rd(4'h0, 8'h00, 8'hff);
    op(8'h61);
    rd(4'h1, 8'h20, 8'hff);
  endtask : t_validate
  // Toggle bit is masked: its value after setup is left open
  task automatic t_setup();
    op(8'h40);
    op(8'h41);
    host.tok(TOK_SETUP, 4'h0, r);
    rd(4'h0, 8'h00, 8'h80);
    rd(4'h1, 8'h00, 8'hff);
    op(8'h40);
    rd(4'h0, 8'h80, 8'h80);
    host.tok(TOK_SETUP, 4'h0, r);
    host.setup_pkt();
    rd(4'h0, 8'h04, 8'hef);
    host.setup_pkt();
    rd(4'h0, 8'h0c, 8'hef);
    rd(4'h0, 8'h04, 8'hef);
    setup_ack_i = 1'b1;
    @(negedge ref_clk_i);
    setup_ack_i = 1'b0;
    rd(4'h0, 8'h00, 8'hef);
    host.setup_pkt();
    rd(4'h0, 8'h04, 8'hef);
    op(8'h40);
    host.setup_pkt();
    rd(4'h0, 8'h84, 8'hef);
  endtask : t_setup
  // Mid-run reset must bring status words 0 and 1 back to zero
  task automatic t_reset();
    nrst_i = 1'b0;
    @(negedge ref_clk_i);
    nrst_i = 1'b1;
    rd(4'h0, 8'h00, 8'hff);
    rd(4'h1, 8'h00, 8'hff);
  endtask : t_reset
  // ----------------------------------------------------------------
  // Sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_stall_all();
    t_tokens();
    t_validate();
    t_setup();
    t_reset();
    results();
  end
endmodule : tb
